// ==== design/rsu_sequencer.sv ====
// rsu_sequencer: remote-upgrade sequencer with records, control and watchdog
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module rsu_sequencer
    import rsu_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        configResetPin,
    input  wire logic        crcError,
    input  wire logic        statusErrorPin,
    input  wire logic        fabricReconfigRequest,
    input  wire logic        watchdogReload,
    input  wire logic        oscTick,
    input  wire logic        userClockInput,
    output logic [1:0]       configState,
    output logic             watchdogTimeoutFlag,
    output logic [23:0]      bootAddress,
    output logic             reconfigBusy
);
    import rsu_pkg::*;

    localparam logic [5:0] HOLD_LAST = 6'(REQ_HOLD_CYCLES - 1);
    localparam logic [5:0] HOLD_MAX  = 6'(REQ_HOLD_CYCLES);
    localparam logic [6:0] LOAD_LAST = 7'(LOAD_CYCLES - 1);

    // reset release through two flops
    logic [1:0] rstPipe_q;
    logic       rstSync_n;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rstPipe_q <= 2'b00;
        end else begin
            rstPipe_q <= {rstPipe_q[0], 1'b1};
        end
    end
    assign rstSync_n = rstPipe_q[1];

    rsu_state_t               state_q;
    rsu_state_t               state_d;
    logic [6:0]               loadCnt_q;
    logic [ADDR_BITS-1:0]     updAddr_q;
    logic [WDOG_BITS-1:0]     updWdog_q;
    logic [ADDR_BITS-1:0]     ctlAddr_q;
    logic [WDOG_BITS-1:0]     ctlWdog_q;
    logic [23:0]              bootAddr_q;
    logic [31:0]              priorCur_q;
    logic [31:0]              priorOld_q;
    logic [SRC_W-1:0]         lastSrc_q;
    logic                     wdFlag_q;
    logic                     appSeen_q;
    logic [2:0]               evtPrev_q;
    logic                     usrPrev_q;
    logic [5:0]               holdCnt_q;
    logic [31:0]              prdata_q;
    logic                     pready_q;
    logic                     pslverr_q;

    // event detection
    logic                     cfgRise;
    logic                     crcRise;
    logic                     statRise;
    logic                     fabricFire;
    logic                     userTick;
    logic                     wdTick;
    logic                     wdEnable;
    logic                     wdExpired;
    logic [SRC_W-1:0]         srcRaw;
    logic [SRC_W-1:0]         srcOneHot;
    logic                     trigger;
    logic                     fromFabric;

    assign cfgRise    = configResetPin & ~evtPrev_q[2];
    assign crcRise    = crcError & ~evtPrev_q[1];
    assign statRise   = statusErrorPin & ~evtPrev_q[0];
    // the request acts once it has been held long enough to be trusted
    assign fabricFire = fabricReconfigRequest && (holdCnt_q == HOLD_LAST);
    assign userTick   = userClockInput & ~usrPrev_q;
    assign wdTick     = ctlWdog_q[WD_USR_POS] ? userTick : oscTick;
    assign wdEnable   = (state_q == ST_APP) && ctlWdog_q[WD_EN_POS];
    assign srcRaw     = {cfgRise, crcRise, statRise, wdExpired, fabricFire};
    assign fromFabric = srcOneHot[SRC_FAB];

    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            evtPrev_q <= 3'h0;
            usrPrev_q <= 1'b0;
            holdCnt_q <= 6'h00;
        end else begin
            evtPrev_q <= {configResetPin, crcError, statusErrorPin};
            usrPrev_q <= userClockInput;
            if (!fabricReconfigRequest) begin
                holdCnt_q <= 6'h00;
            end else if (holdCnt_q != HOLD_MAX) begin
                holdCnt_q <= holdCnt_q + 6'h01;
            end
        end
    end

    rsu_src_priority u_priority (
        .clock     (clock),
        .rstSync_n (rstSync_n),
        .srcRaw    (srcRaw),
        .srcOneHot (srcOneHot),
        .srcAny    (trigger)
    );

    rsu_watchdog u_watchdog (
        .clock        (clock),
        .rstSync_n    (rstSync_n),
        .enable       (wdEnable),
        .tick         (wdTick),
        .reload       (watchdogReload),
        .timeoutValue (ctlWdog_q[WD_PROG_BITS-1:0]),
        .expired      (wdExpired)
    );

    // master state machine
    logic [ADDR_BITS-1:0] ctlAddr_d;
    logic [WDOG_BITS-1:0] ctlWdog_d;
    logic                 loadDone;

    assign ctlAddr_d = fromFabric ? updAddr_q : CTL_ADDR_RST;
    assign ctlWdog_d = fromFabric ? updWdog_q : CTL_WDOG_RST;
    assign loadDone  = (state_q == ST_LOAD) && (loadCnt_q == LOAD_LAST);

    // an all-zero address field (bits 21..0) of the control word selects the factory image; the option bits are ignored
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_FACTORY: if (trigger) state_d = ST_LOAD;
            ST_APP:     if (trigger) state_d = ST_LOAD;
            ST_LOAD: begin
                if (trigger) begin
                    state_d = ST_LOAD;
                end else if (loadDone) begin
                    state_d = (ctlAddr_q[ADDR_W-1:0] == '0) ? ST_FACTORY : ST_APP;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state_q   <= ST_FACTORY;
            loadCnt_q <= 7'h00;
        end else begin
            state_q   <= state_d;
            loadCnt_q <= (trigger || state_q != ST_LOAD) ? 7'h00 : loadCnt_q + 7'h01;
        end
    end

    // control register: only the sequencer writes it
    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            ctlAddr_q  <= CTL_ADDR_RST;
            ctlWdog_q  <= CTL_WDOG_RST;
            bootAddr_q <= 24'h00_0000;
        end else if (trigger) begin
            ctlAddr_q  <= ctlAddr_d;
            ctlWdog_q  <= ctlWdog_d;
            bootAddr_q <= {ctlAddr_d[ADDR_W-1:0], 2'b00};
        end
    end

    // records and status change in the trigger cycle, ahead of any load
    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            priorCur_q <= RECORD_RST;
            priorOld_q <= RECORD_RST;
            lastSrc_q  <= '0;
            wdFlag_q   <= 1'b0;
        end else if (trigger) begin
            priorOld_q <= priorCur_q;
            priorCur_q <= {1'b0, srcOneHot, stateCode(state_q), bootAddr_q};
            lastSrc_q  <= srcOneHot;
            wdFlag_q   <= srcOneHot[SRC_WD];
        end
    end

    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            appSeen_q <= 1'b0;
        end else if (state_q == ST_APP) begin
            appSeen_q <= 1'b1;
        end
    end

    // register bus: one wait state, answer registered
    logic        apbAccess;
    logic        readyNext;
    logic        inFactory;
    logic        isUpdAddr;
    logic        isUpdWdog;
    logic        isUpd;
    logic        isMapped;
    logic        busErr;
    logic        wrEn;
    logic [31:0] rdMux;
    logic [31:0] statusWord;
    logic [31:0] priorCurView;
    logic [31:0] priorOldView;

    assign apbAccess = psel & penable;
    assign readyNext = apbAccess & ~pready_q;
    assign inFactory = (state_q == ST_FACTORY);
    assign isUpdAddr = (paddr == OFS_UPD_ADDR);
    assign isUpdWdog = (paddr == OFS_UPD_WDOG);
    assign isUpd     = isUpdAddr | isUpdWdog;
    assign isMapped  = isUpd | (paddr == OFS_CTL_ADDR) | (paddr == OFS_CTL_WDOG)
                     | (paddr == OFS_PRIOR_CUR) | (paddr == OFS_PRIOR_OLD) | (paddr == OFS_STATUS);
    // control, records and status refuse writes; update refuses outside factory
    assign busErr    = !isMapped || (pwrite && !(isUpd && inFactory));
    assign wrEn      = apbAccess & pready_q & pwrite & ~pslverr_q & isUpd & inFactory;

    assign priorCurView = appSeen_q ? priorCur_q : CAPTURE_BAD_VALUE;
    assign priorOldView = appSeen_q ? priorOld_q : CAPTURE_BAD_VALUE;
    assign statusWord   = {23'h00_0000, appSeen_q, stateCode(state_q), wdFlag_q, lastSrc_q};

    always_comb begin
        unique case (paddr)
            OFS_UPD_ADDR:  rdMux = {8'h00, updAddr_q};
            OFS_UPD_WDOG:  rdMux = {18'h0_0000, updWdog_q};
            OFS_CTL_ADDR:  rdMux = {8'h00, ctlAddr_q};
            OFS_CTL_WDOG:  rdMux = {18'h0_0000, ctlWdog_q};
            OFS_PRIOR_CUR: rdMux = priorCurView;
            OFS_PRIOR_OLD: rdMux = priorOldView;
            OFS_STATUS:    rdMux = statusWord;
            default:       rdMux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= readyNext;
            pslverr_q <= readyNext & busErr;
            prdata_q  <= (readyNext && !pwrite && isMapped) ? rdMux : 32'h0000_0000;
        end
    end

    // update register: written only by fabric logic over the bus
    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            updAddr_q <= UPD_ADDR_RST;
            updWdog_q <= UPD_WDOG_RST;
        end else if (wrEn) begin
            if (isUpdAddr) updAddr_q <= pwdata[ADDR_BITS-1:0];
            if (isUpdWdog) updWdog_q <= pwdata[WDOG_BITS-1:0];
        end
    end

    // outputs
    logic [1:0] cfgState_q;
    logic       busy_q;

    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            cfgState_q <= MS_CODE_FACTORY;
            busy_q     <= 1'b0;
        end else begin
            cfgState_q <= stateCode(state_d);
            busy_q     <= (state_d == ST_LOAD);
        end
    end

    assign prdata              = prdata_q;
    assign pready              = pready_q;
    assign pslverr             = pslverr_q;
    assign configState         = cfgState_q;
    assign watchdogTimeoutFlag = wdFlag_q;
    assign bootAddress         = bootAddr_q;
    assign reconfigBusy        = busy_q;

    AST_RECORD_SHIFT: assert property (@(posedge clock) disable iff (!rstSync_n)
        trigger |=> priorOld_q == $past(priorCur_q) && priorCur_q[30:26] == $past(srcOneHot))
        else $error("records did not shift on trigger");
    AST_RECORD_STATE: assert property (@(posedge clock) disable iff (!rstSync_n)
        trigger |=> priorCur_q[25:24] == stateCode($past(state_q)))
        else $error("record state code wrong");
    AST_RECORD_BOOT: assert property (@(posedge clock) disable iff (!rstSync_n)
        trigger |=> priorCur_q[23:0] == $past(bootAddr_q))
        else $error("record boot address wrong");
    AST_BAD_CAPTURE: assert property (@(posedge clock) disable iff (!rstSync_n)
        readyNext && !pwrite && paddr == OFS_PRIOR_CUR && !appSeen_q |=> prdata == 32'h7C00_0000)
        else $error("early capture not flagged");
    AST_UPD_LOCK: assert property (@(posedge clock) disable iff (!rstSync_n)
        state_q != ST_FACTORY |=> $stable(updAddr_q) && $stable(updWdog_q))
        else $error("update changed outside factory");
    AST_CTL_COPY: assert property (@(posedge clock) disable iff (!rstSync_n)
        trigger && fromFabric |=> ctlAddr_q == $past(updAddr_q) && ctlWdog_q == $past(updWdog_q))
        else $error("update not copied to control");
    AST_CTL_CLEAR: assert property (@(posedge clock) disable iff (!rstSync_n)
        trigger && !fromFabric |=> ctlAddr_q == 24'h00_0000 && ctlWdog_q == 14'h0000)
        else $error("control not cleared on error");
    AST_STATUS_FIRST: assert property (@(posedge clock) disable iff (!rstSync_n)
        trigger |=> state_q == ST_LOAD && lastSrc_q == $past(srcOneHot) ##1 state_q == ST_LOAD)
        else $error("status not updated before load");
    AST_WD_OFF: assert property (@(posedge clock) disable iff (!rstSync_n)
        state_q != ST_APP |-> !wdEnable)
        else $error("watchdog active outside application");
    AST_WD_FLAG: assert property (@(posedge clock) disable iff (!rstSync_n)
        wdExpired && srcRaw[4:2] == 3'b000 |=> wdFlag_q && state_q == ST_LOAD && ctlAddr_q == 24'h00_0000)
        else $error("timeout did not flag and fall back");
endmodule : rsu_sequencer
`default_nettype wire

// ==== design/rsu_src_priority.sv ====
// rsu_src_priority: keeps only the highest reconfiguration source
`timescale 1ns/1ps
`default_nettype none
module rsu_src_priority
    import rsu_pkg::*;
(
    input  wire logic             clock,
    input  wire logic             rstSync_n,
    input  wire logic [SRC_W-1:0] srcRaw,
    output logic      [SRC_W-1:0] srcOneHot,
    output logic                  srcAny
);
    always_comb begin
        srcOneHot = '0;
        for (int i = 0; i < SRC_W; i++) begin
            if (srcRaw[i]) begin
                srcOneHot = SRC_W'(1 << i);
            end
        end
    end
    assign srcAny = |srcRaw;

    AST_SRC_ONEHOT: assert property (@(posedge clock) disable iff (!rstSync_n)
        srcAny |-> $onehot(srcOneHot))
        else $error("source field not one-hot");
    AST_SRC_PRIORITY: assert property (@(posedge clock) disable iff (!rstSync_n)
        srcRaw[SRC_CFG] |-> srcOneHot[SRC_CFG] && !srcOneHot[SRC_FAB])
        else $error("config reset did not win");
endmodule : rsu_src_priority
`default_nettype wire

// ==== design/rsu_watchdog.sv ====
// rsu_watchdog: 29-bit user watchdog down-counter
`timescale 1ns/1ps
`default_nettype none
module rsu_watchdog
    import rsu_pkg::*;
(
    input  wire logic                    clock,
    input  wire logic                    rstSync_n,
    input  wire logic                    enable,
    input  wire logic                    tick,
    input  wire logic                    reload,
    input  wire logic [WD_PROG_BITS-1:0] timeoutValue,
    output logic                         expired
);
    logic [WD_CNT_BITS-1:0] cnt_q;
    logic                   expired_q;
    logic [WD_CNT_BITS-1:0] loadVal;
    logic                   lastTick;

    assign loadVal  = {timeoutValue, {WD_LOW_BITS{1'b0}}};
    assign lastTick = tick && (cnt_q <= WD_CNT_BITS'(1));
    assign expired  = expired_q;

    // held loaded while disabled, so counting starts on entry to user mode
    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            cnt_q     <= '0;
            expired_q <= 1'b0;
        end else if (!enable || reload) begin
            cnt_q     <= loadVal;
            expired_q <= 1'b0;
        end else if (tick) begin
            cnt_q     <= lastTick ? loadVal : cnt_q - WD_CNT_BITS'(1);
            expired_q <= lastTick;
        end else begin
            expired_q <= 1'b0;
        end
    end

    AST_WD_RELOAD: assert property (@(posedge clock) disable iff (!rstSync_n)
        enable && reload |=> cnt_q == {$past(timeoutValue), 17'h0_0000} && !expired_q)
        else $error("reload did not restart the count");
    AST_WD_IDLE: assert property (@(posedge clock) disable iff (!rstSync_n)
        !enable ##1 !enable |-> !expired_q)
        else $error("watchdog expired while disabled");
endmodule : rsu_watchdog
`default_nettype wire

// ==== shared/rsu_pkg.sv ====
// rsu_pkg: constants, types and helpers of the remote-upgrade sequencer
// Behaviour
// - two prior-state records, current and older
// - bits 30..26 one-hot reconfiguration source
// - simultaneous sources keep highest bit only
// - bits 25..24 hold master state on exit
// - bits 23..0 hold boot address used
// - early capture returns a distinctive value
// - update changes only in factory, control on any trigger
// - fabric writes update, sequencer writes control
// - fabric request copies update into control
// - triggers set control for factory or application
// - status updated before factory load begins
// - error triggers clear control, fabric copies update
// - watchdog off in factory, on in application
// - 29-bit watchdog programmed by top 12 bits
// - watchdog counts oscillator or user clock
// - watchdog starts in user mode, reload restarts
// - expiry sets watchdog flag, reloads factory
package rsu_pkg;
    localparam int CLOCK_PERIOD_NS = 8;
    localparam int REQ_HOLD_NS     = 250;
    localparam int REQ_HOLD_CYCLES = (REQ_HOLD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int LOAD_CYCLES     = 64;

    localparam logic [7:0] OFS_UPD_ADDR  = 8'h00;
    localparam logic [7:0] OFS_UPD_WDOG  = 8'h04;
    localparam logic [7:0] OFS_CTL_ADDR  = 8'h08;
    localparam logic [7:0] OFS_CTL_WDOG  = 8'h0C;
    localparam logic [7:0] OFS_PRIOR_CUR = 8'h10;
    localparam logic [7:0] OFS_PRIOR_OLD = 8'h14;
    localparam logic [7:0] OFS_STATUS    = 8'h18;

    // address word: config address and the two startup option bits
    localparam int ADDR_W    = 22;
    localparam int OSC_POS   = 22;
    localparam int EARLY_POS = 23;
    localparam int ADDR_BITS = 24;
    // watchdog word: programmed value, enable, clock select
    localparam int WD_PROG_BITS = 12;
    localparam int WD_LOW_BITS  = 17;
    localparam int WD_CNT_BITS  = 29;
    localparam int WD_EN_POS    = 12;
    localparam int WD_USR_POS   = 13;
    localparam int WDOG_BITS    = 14;

    localparam logic [ADDR_BITS-1:0] UPD_ADDR_RST = 24'hC0_0000;
    localparam logic [WDOG_BITS-1:0] UPD_WDOG_RST = 14'h1000;
    localparam logic [ADDR_BITS-1:0] CTL_ADDR_RST = 24'h00_0000;
    localparam logic [WDOG_BITS-1:0] CTL_WDOG_RST = 14'h0000;
    localparam logic [31:0]          RECORD_RST   = 32'h0000_0000;

    // record layout
    localparam int SRC_W    = 5;
    localparam int SRC_LO   = 26;
    localparam int STATE_LO = 24;
    localparam int SRC_CFG  = 4;
    localparam int SRC_CRC  = 3;
    localparam int SRC_STAT = 2;
    localparam int SRC_WD   = 1;
    localparam int SRC_FAB  = 0;
    // several source bits at once can never be a genuine record
    localparam logic [31:0] CAPTURE_BAD_VALUE = 32'h7C00_0000;

    // status word layout
    localparam int ST_FLAG_POS  = 5;
    localparam int ST_CODE_LO   = 6;
    localparam int ST_SEEN_POS  = 8;

    localparam logic [1:0] MS_CODE_FACTORY = 2'h0;
    localparam logic [1:0] MS_CODE_APP     = 2'h1;
    localparam logic [1:0] MS_CODE_LOAD    = 2'h2;

    typedef enum logic [1:0] {ST_FACTORY, ST_LOAD, ST_APP} rsu_state_t;

    function automatic logic [1:0] stateCode(input rsu_state_t s);
        unique case (s)
            ST_FACTORY: stateCode = MS_CODE_FACTORY;
            ST_APP:     stateCode = MS_CODE_APP;
            ST_LOAD:    stateCode = MS_CODE_LOAD;
            default:    stateCode = MS_CODE_LOAD;
        endcase
    endfunction : stateCode
endpackage : rsu_pkg

// ==== tb/rsu_fabric_model.sv ====
// rsu_fabric_model: fabric user logic that raises reconfiguration and watchdog reload strobes
`timescale 1ns/1ps
`default_nettype none
module rsu_fabric_model (
    input  wire logic clock,
    output logic      fabricReconfigRequest,
    output logic      watchdogReload,
    output logic      userClockInput
);
    import rsu_pkg::*;

    // the user clock stands still unless a test pulses it
    initial begin
        fabricReconfigRequest = 1'b0;
        watchdogReload        = 1'b0;
        userClockInput        = 1'b0;
    end

    // held two cycles past the minimum so the request is never borderline
    task automatic requestReconfig();
        @(posedge clock);
        fabricReconfigRequest <= 1'b1;
        repeat (REQ_HOLD_CYCLES + 2) @(posedge clock);
        fabricReconfigRequest <= 1'b0;
    endtask : requestReconfig

    // the caller keeps the level for far longer than the minimum hold
    task automatic holdReload(input logic level);
        @(posedge clock);
        watchdogReload <= level;
    endtask : holdReload

    // one user clock period, high for one sampled cycle
    task automatic pulseUserClock();
        @(posedge clock);
        userClockInput <= 1'b1;
        @(posedge clock);
        userClockInput <= 1'b0;
    endtask : pulseUserClock
endmodule : rsu_fabric_model
`default_nettype wire

// ==== tb/rsu_sequencer_test.sv ====
// rsu_sequencer_test: self-checking bench of the remote-upgrade sequencer
`timescale 1ns/1ps
`default_nettype none
module rsu_sequencer_test;
    import rsu_pkg::*;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
    logic        pready, pslverr, rerr, fabReq, wdReload, usrClk, wdFlag, busy;
    logic        cfgPin = 1'b0, crcErr = 1'b0, statPin = 1'b0, oscTick = 1'b0;
    logic [1:0]  cfgState;
    logic [23:0] bootAddr;
    int          badCount = 0, cmpCount = 0;

    always #4 clock = ~clock;

    rsu_fabric_model fabric (.clock(clock), .fabricReconfigRequest(fabReq), .watchdogReload(wdReload),
        .userClockInput(usrClk));
    rsu_sequencer DUT (.clock(clock), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .configResetPin(cfgPin), .crcError(crcErr), .statusErrorPin(statPin),
        .fabricReconfigRequest(fabReq), .watchdogReload(wdReload), .oscTick(oscTick),
        .userClockInput(usrClk), .configState(cfgState), .watchdogTimeoutFlag(wdFlag),
        .bootAddress(bootAddr), .reconfigBusy(busy));

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmpCount, badCount);
        if (badCount == 0 && cmpCount > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, seen);
            badCount++;
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] adr, input logic [31:0] wdat);
        int n;
        n = 0;
        @(posedge clock);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= adr;
        pwdata  <= wdat;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            badCount++;
            end_of_test();
        end
        rdat    = prdata;
        rerr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] adr, input logic [31:0] exp, input logic expErr);
        apb(1'b0, adr, 32'h0000_0000);
        chk("read data", rdat, exp);
        chk("read error", {31'h0, rerr}, {31'h0, expErr});
    endtask : rd

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat, input logic expErr);
        apb(1'b1, adr, dat);
        chk("write error", {31'h0, rerr}, {31'h0, expErr});
    endtask : wr

    task automatic waitLoad();
        int n;
        n = 0;
        while (busy !== 1'b1 && n < 100) begin
            @(posedge clock);
            n++;
        end
        // a load that never starts must not pass as a finished one
        if (busy !== 1'b1) begin
            badCount++;
            end_of_test();
        end
        while (busy !== 1'b0 && n < 300) begin
            @(posedge clock);
            n++;
        end
        if (n >= 300 || busy !== 1'b0) begin
            badCount++;
            end_of_test();
        end
        repeat (2) @(posedge clock);
    endtask : waitLoad

    task automatic tick();
        @(posedge clock);
        oscTick <= 1'b1;
        @(posedge clock);
        oscTick <= 1'b0;
        repeat (3) @(posedge clock);
    endtask : tick

    task automatic trig(input logic [2:0] which);
        @(posedge clock);
        {cfgPin, crcErr, statPin} <= which;
        @(posedge clock);
        {cfgPin, crcErr, statPin} <= 3'b000;
        waitLoad();
    endtask : trig

    task automatic testReset();
        rd(OFS_UPD_ADDR, {8'h00, UPD_ADDR_RST}, 1'b0);
        rd(OFS_UPD_WDOG, {18'h0, UPD_WDOG_RST}, 1'b0);
        rd(OFS_CTL_ADDR, 32'h0000_0000, 1'b0);
        rd(OFS_PRIOR_CUR, CAPTURE_BAD_VALUE, 1'b0);
        rd(8'h1C, 32'h0000_0000, 1'b1);
        $display("test reset done");
    endtask : testReset

    task automatic testFabric();
        // reset update word lands in factory with the watchdog enable bit set
        fabric.requestReconfig();
        waitLoad();
        tick();
        chk("factory state", {30'h0, cfgState}, 32'h0);
        chk("factory busy", {31'h0, busy}, 32'h0);
        rd(OFS_CTL_WDOG, {18'h0, UPD_WDOG_RST}, 1'b0);
        wr(OFS_UPD_ADDR, 32'h00C0_0100, 1'b0);
        wr(OFS_UPD_WDOG, 32'h0000_1000, 1'b0);
        wr(OFS_CTL_ADDR, 32'h0000_0001, 1'b1);
        fabric.holdReload(1'b1);
        fabric.requestReconfig();
        waitLoad();
        chk("app state", {30'h0, cfgState}, 32'h1);
        chk("boot address", {8'h0, bootAddr}, 32'h0000_0400);
        rd(OFS_CTL_ADDR, 32'h00C0_0100, 1'b0);
        rd(OFS_CTL_WDOG, 32'h0000_1000, 1'b0);
        wr(OFS_UPD_ADDR, 32'h0000_0000, 1'b1);
        $display("test fabric done");
    endtask : testFabric

    task automatic testWatchdog();
        tick();
        chk("held watchdog", {30'h0, cfgState}, 32'h1);
        fabric.holdReload(1'b0);
        tick();
        waitLoad();
        chk("timeout flag", {31'h0, wdFlag}, 32'h1);
        chk("fallback state", {30'h0, cfgState}, 32'h0);
        rd(OFS_CTL_ADDR, 32'h0000_0000, 1'b0);
        apb(1'b0, OFS_STATUS, 32'h0000_0000);
        chk("status", rdat & 32'h0000_003F, 32'h0000_0022);
        rd(OFS_PRIOR_CUR, 32'h0900_0400, 1'b0);
        rd(OFS_PRIOR_OLD, 32'h0400_0000, 1'b0);
        $display("test watchdog done");
    endtask : testWatchdog

    task automatic testPriority();
        trig(3'b110);
        chk("timeout flag", {31'h0, wdFlag}, 32'h0);
        rd(OFS_PRIOR_CUR, 32'h4000_0000, 1'b0);
        rd(OFS_PRIOR_OLD, 32'h0900_0400, 1'b0);
        trig(3'b001);
        rd(OFS_PRIOR_CUR, 32'h1000_0000, 1'b0);
        $display("test priority done");
    endtask : testPriority

    task automatic testUserClock();
        wr(OFS_UPD_WDOG, 32'h0000_3000, 1'b0);
        fabric.requestReconfig();
        waitLoad();
        chk("user app state", {30'h0, cfgState}, 32'h1);
        tick();
        chk("osc ignored", {30'h0, cfgState}, 32'h1);
        fabric.pulseUserClock();
        waitLoad();
        chk("user timeout flag", {31'h0, wdFlag}, 32'h1);
        chk("user fallback", {30'h0, cfgState}, 32'h0);
        rd(OFS_PRIOR_CUR, 32'h0900_0400, 1'b0);
        $display("test user clock done");
    endtask : testUserClock

    initial begin
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        testReset();
        testFabric();
        testWatchdog();
        testPriority();
        testUserClock();
        end_of_test();
    end
endmodule : rsu_sequencer_test
`default_nettype wire
